// >>> inc/shbp_defs.vh
/*
 * shbp_defs.vh: timing counts and address constants for the host-side
 * sram-like bus controller. Assumes a 40 MHz core clock (25 ns period).
 */
`ifndef SHBP_DEFS_VH
`define SHBP_DEFS_VH

`define SHBP_CLK_PERIOD_NS      25
// least times, ns
`define SHBP_T_CSL_NS           32
`define SHBP_T_CYCLE_NS         45
`define SHBP_T_CSH_NS           13
`define SHBP_T_CSDV_NS          30
`define SHBP_T_ACYC_NS          45
`define SHBP_T_ADV_NS           40
`define SHBP_T_FIFO_INF_NS      135
`define SHBP_T_RX_DROP_NS       180
`define SHBP_T_WR_RD_MAX_NS     315
// least times round up to whole cycles
`define SHBP_CYC(ns)            (((ns) + `SHBP_CLK_PERIOD_NS - 1) / `SHBP_CLK_PERIOD_NS)
`define SHBP_CSL_CYC            `SHBP_CYC(`SHBP_T_CSL_NS)
`define SHBP_CSH_CYC            `SHBP_CYC(`SHBP_T_CSH_NS)
`define SHBP_CSDV_CYC           `SHBP_CYC(`SHBP_T_CSDV_NS)
`define SHBP_ADV_CYC            `SHBP_CYC(`SHBP_T_ADV_NS)
`define SHBP_ACYC_CYC           `SHBP_CYC(`SHBP_T_ACYC_NS)
`define SHBP_FIFO_INF_CYC       `SHBP_CYC(`SHBP_T_FIFO_INF_NS)
`define SHBP_RX_DROP_CYC        `SHBP_CYC(`SHBP_T_RX_DROP_NS)
`define SHBP_WR_RD_CYC          `SHBP_CYC(`SHBP_T_WR_RD_MAX_NS)
// burst limits
`define SHBP_BURST_MAX_32       5'h08
`define SHBP_BURST_MAX_16       5'h10
// word addresses (address bits 7:1) of resources with read hazards
`define SHBP_ADDR_RX_DATA       7'h00
`define SHBP_ADDR_RX_STS        7'h20
`define SHBP_ADDR_TX_STS        7'h24
`define SHBP_ADDR_RX_FIFO_LEVEL_INFO   7'h3E
`define SHBP_ADDR_TX_FIFO_LEVEL_INFO   7'h40
`define SHBP_ADDR_RX_DROP       7'h50

`endif

// >>> logic/shbp_host_port.v
/*
 * shbp_host_port.v: host-side controller driving an sram-like device port
 * (chip select, read/write strobes, address, 32-bit data, fifo select).
 * Assumes a user request port in the core clock domain; device data pins
 * are asynchronous and are synchronised before use.
 */
`timescale 1ns/100ps
`default_nettype none
`include "shbp_defs.vh"

module shbp_host_port #(
  parameter WR_RD_CYC = `SHBP_WR_RD_CYC
) (
  input  wire        i_core_clk,
  input  wire        i_nrst,
  input  wire        i_req_valid,
  input  wire        i_req_write,
  input  wire        i_req_wide,
  input  wire        i_req_fifo,
  input  wire [6:0]  i_req_addr,
  input  wire [31:0] i_req_wdata,
  input  wire [4:0]  i_req_len,
  output reg         o_req_ready,
  output reg         o_rdata_valid,
  output reg  [31:0] o_rdata,
  output reg         o_done,
  output reg         o_chip_select_n,
  output reg         o_read_strobe_n,
  output reg         o_write_strobe_n,
  output reg         o_fifo_sel,
  output reg  [6:0]  o_addr,
  output reg  [31:0] o_data_out,
  output reg         o_data_oe,
  input  wire [31:0] i_data_in
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_WR    = 3'd1;
  localparam [2:0] ST_RD    = 3'd2;
  localparam [2:0] ST_GAP   = 3'd3;
  localparam [2:0] ST_GUARD = 3'd4;

  localparam integer CSL_I  = `SHBP_CSL_CYC;
  localparam integer CYC_I  = `SHBP_ACYC_CYC;
  localparam integer CSH_I  = `SHBP_CSH_CYC;
  localparam integer SMP_I  = `SHBP_ADV_CYC + 2;
  localparam integer FINF_I = `SHBP_FIFO_INF_CYC;
  localparam integer DROP_I = `SHBP_RX_DROP_CYC;

  // counts fit the 4-bit tick and wait timers
  localparam [3:0] CSL_C  = CSL_I[3:0];
  localparam [3:0] CYC_C  = CYC_I[3:0];
  localparam [3:0] CSH_C  = CSH_I[3:0];
  localparam [3:0] SMP_C  = SMP_I[3:0];
  localparam [3:0] FINF_C = FINF_I[3:0];
  localparam [3:0] DROP_C = DROP_I[3:0];
  localparam [3:0] WRRD_C = WR_RD_CYC[3:0];

  reg [2:0]  state_reg;
  reg [3:0]  tick_reg;
  reg [4:0]  left_reg;
  reg        wide_reg;
  reg [31:0] sync1_reg;
  reg [31:0] sync2_reg;

  wire rx_busy;
  wire tx_busy;
  wire drop_busy;
  wire wr_busy;

  // read-after-read hazard sources, armed by every beat that reads them
  wire rx_src   = o_fifo_sel || (o_addr == `SHBP_ADDR_RX_DATA)
                  || (o_addr == `SHBP_ADDR_RX_STS);
  wire tx_src   = !o_fifo_sel && (o_addr == `SHBP_ADDR_TX_STS);
  wire drop_src = !o_fifo_sel && (o_addr == `SHBP_ADDR_RX_DROP);
  wire rd_beat  = (state_reg == ST_RD) && (tick_reg == SMP_C);
  wire wr_end   = (state_reg == ST_WR) && (tick_reg >= CSL_C) && (tick_reg >= CYC_C);

  shbp_wait_timer u_rx_wait (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_load(rd_beat && rx_src), .i_count(FINF_C), .o_busy(rx_busy));
  shbp_wait_timer u_tx_wait (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_load(rd_beat && tx_src), .i_count(FINF_C), .o_busy(tx_busy));
  shbp_wait_timer u_drop_wait (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_load(rd_beat && drop_src), .i_count(DROP_C), .o_busy(drop_busy));
  shbp_wait_timer u_wr_wait (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_load(wr_end), .i_count(WRRD_C), .o_busy(wr_busy));

  // a read waits while its target still has a pending hazard
  wire blocked = !i_req_write && (wr_busy
                 || (!i_req_fifo && (i_req_addr == `SHBP_ADDR_RX_FIFO_LEVEL_INFO) && rx_busy)
                 || (!i_req_fifo && (i_req_addr == `SHBP_ADDR_TX_FIFO_LEVEL_INFO) && tx_busy)
                 || (!i_req_fifo && (i_req_addr == `SHBP_ADDR_RX_DROP) && drop_busy));

  // burst length clamp: direct fifo bursts up to 31, else 8 or 16
  wire [4:0] max_len = i_req_fifo ? 5'h1F
                     : (i_req_wide ? `SHBP_BURST_MAX_32 : `SHBP_BURST_MAX_16);
  wire [4:0] len_in  = (i_req_write || (i_req_len == 5'd0)) ? 5'd1
                     : ((i_req_len > max_len) ? max_len : i_req_len);
  wire       accept  = (state_reg == ST_IDLE) && i_req_valid && !blocked;

  always @(posedge i_core_clk) begin
    sync1_reg <= i_data_in;
    sync2_reg <= sync1_reg;
  end

  always @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_reg        <= ST_IDLE;
      tick_reg         <= 4'h0;
      left_reg         <= 5'h00;
      wide_reg         <= 1'b0;
      o_req_ready      <= 1'b0;
      o_rdata_valid    <= 1'b0;
      o_rdata          <= 32'h00000000;
      o_done           <= 1'b0;
      o_chip_select_n  <= 1'b1;
      o_read_strobe_n  <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_fifo_sel       <= 1'b0;
      o_addr           <= 7'h00;
      o_data_out       <= 32'h00000000;
      o_data_oe        <= 1'b0;
    end else begin
      o_rdata_valid <= 1'b0;
      o_done        <= 1'b0;
      o_req_ready   <= 1'b0;
      tick_reg      <= tick_reg + 4'h1;
      case (state_reg)
        ST_IDLE: begin
          tick_reg    <= 4'h1;
          o_req_ready <= i_req_valid && !blocked;
          if (accept) begin
            // address and fifo select set with the strobes
            o_addr          <= i_req_addr;
            o_fifo_sel      <= i_req_fifo;
            wide_reg        <= i_req_wide;
            left_reg        <= len_in;
            o_chip_select_n <= 1'b0;
            if (i_req_write) begin
              o_write_strobe_n <= 1'b0;
              o_data_out <= i_req_wide ? i_req_wdata
                                       : {16'h0000, i_req_wdata[15:0]};
              o_data_oe  <= 1'b1;
              state_reg  <= ST_WR;
            end else begin
              o_read_strobe_n <= 1'b0;
              state_reg       <= ST_RD;
            end
          end
        end
        ST_WR: begin
          if (wr_end) begin
            o_chip_select_n  <= 1'b1;
            o_write_strobe_n <= 1'b1;
            o_done           <= 1'b1;
            tick_reg         <= 4'h1;
            state_reg        <= ST_GAP;
          end
        end
        ST_RD: begin
          // sample after data valid plus two synchroniser stages
          if (tick_reg == SMP_C) begin
            o_rdata_valid <= 1'b1;
            o_rdata <= wide_reg ? sync2_reg : {16'h0000, sync2_reg[15:0]};
            left_reg <= left_reg - 5'd1;
            tick_reg <= 4'h1;
            if (left_reg == 5'd1) begin
              o_chip_select_n <= 1'b1;
              o_read_strobe_n <= 1'b1;
              o_done          <= 1'b1;
              state_reg       <= ST_GAP;
            end else begin
              // next burst beat; fifo bursts step too, so each beat is a new cycle
              o_addr <= o_addr + (wide_reg ? 7'h02 : 7'h01);
            end
          end
        end
        ST_GAP: begin
          o_data_oe <= 1'b0;
          if (tick_reg >= CSH_C)
            state_reg <= ST_GUARD;
        end
        ST_GUARD: begin
          tick_reg  <= 4'h1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // shbp_host_port

`default_nettype wire

// >>> logic/shbp_wait_timer.v
/*
 * shbp_wait_timer.v: loadable down-counter; o_busy is high while counting.
 * Assumes load and count values come from the same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module shbp_wait_timer #(
  parameter W = 4
) (
  input  wire         i_core_clk,
  input  wire         i_nrst,
  input  wire         i_load,
  input  wire [W-1:0] i_count,
  output wire         o_busy
);

  reg [W-1:0] cnt_reg;

  always @(posedge i_core_clk) begin
    if (!i_nrst)
      cnt_reg <= {W{1'b0}};
    else if (i_load && (i_count > cnt_reg))
      cnt_reg <= i_count;
    else if (cnt_reg != {W{1'b0}})
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
  end

  assign o_busy = (cnt_reg != {W{1'b0}});

endmodule // shbp_wait_timer

`default_nettype wire

// >>> verification/shbp_dev_model.sv
/* shbp_dev_model: device side of the pins. Assumes host-driven pins. */
`timescale 1ns/100ps
`default_nettype none
module shbp_dev_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_chip_select_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_fifo_sel,
  input  wire logic [6:0]  i_addr,
  input  wire logic [31:0] i_data,
  output logic      [31:0] o_data,
  output logic      [31:0] o_wr_data
);
  logic [31:0] last_reg = 32'h0;
  logic        rd_q = 1'b0;
  logic [6:0]  addr_q = 7'h00;
  int          pops = 0;
  wire rd = !i_chip_select_n && !i_read_strobe_n;
  wire wr = !i_chip_select_n && !i_write_strobe_n;
  // fifo select: only a[2:1] decoded
  wire [31:0] val = i_fifo_sel ? {16'hF1F0, 14'h0, i_addr[1:0]} : {16'hA55A, 9'h0, i_addr};
  assign o_data = rd ? val : ~last_reg;
  always @(posedge i_core_clk) begin
    if (rd) last_reg <= val;
    if (wr) o_wr_data <= i_data;
    // one pop per read cycle: strobe start or address step
    if (rd && i_fifo_sel && (!rd_q || i_addr != addr_q)) pops <= pops + 1;
    rd_q <= rd;
    addr_q <= i_addr;
  end
endmodule // shbp_dev_model
`default_nettype wire

// >>> verification/shbp_host_port_assertions.sv
/* shbp_chk: pin timing checks. Assumes binding to shbp_host_port ports. */
`timescale 1ns/100ps
`default_nettype none
module shbp_chk (
  input wire logic       i_core_clk,
  input wire logic       i_nrst,
  input wire logic       o_chip_select_n,
  input wire logic       o_read_strobe_n,
  input wire logic       o_write_strobe_n,
  input wire logic       o_fifo_sel,
  input wire logic [6:0] o_addr,
  input wire logic       o_data_oe,
  input wire logic       o_rdata_valid,
  input wire logic       o_done
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire act = !o_chip_select_n && !(o_read_strobe_n && o_write_strobe_n);
  logic [4:0] beats_reg;
  always @(posedge i_core_clk)
    beats_reg <= (!i_nrst || !act) ? 5'h00 : beats_reg + 5'(o_rdata_valid);
  strobe_len_a: assert property ($rose(act) |-> act[*2])
    else $error("short strobe");
  gap_len_a: assert property ($fell(act) |-> !act[*2])
    else $error("short gap");
  sel_hold_a: assert property (act && $past(act) |-> $stable(o_fifo_sel))
    else $error("select moved");
  addr_step_a: assert property (act && $changed(o_addr) |=> !act || $stable(o_addr))
    else $error("fast address");
  read_bus_a: assert property (!o_read_strobe_n |-> !o_data_oe)
    else $error("bus clash");
  write_len_a: assert property ($fell(o_write_strobe_n) |-> ##2 ($rose(o_write_strobe_n) && o_done))
    else $error("write length");
  read_beat_a: assert property ($fell(o_read_strobe_n) |-> ##4 o_rdata_valid)
    else $error("late data");
  burst_max_a: assert property (act && !o_fifo_sel |-> beats_reg < 5'h10)
    else $error("long burst");
  cover property ($rose(act) && !o_write_strobe_n);
  cover property ($rose(act) && o_fifo_sel);
  cover property (beats_reg == 5'h0F);
endmodule // shbp_chk
bind shbp_host_port shbp_chk u_chk (.*);
`default_nettype wire

// >>> verification/shbp_host_port_tb.sv
/* shbp_host_port_tb: scenarios with shbp_dev_model. Assumes checker bound. */
`timescale 1ns/100ps
`default_nettype none
module shbp_host_port_tb;
  logic        i_core_clk = 0, i_nrst = 0, i_req_valid = 0, i_req_write = 0;
  logic        i_req_wide = 0, i_req_fifo = 0;
  logic [6:0]  i_req_addr = 7'h00;
  logic [31:0] i_req_wdata = 32'h0;
  logic [4:0]  i_req_len = 5'h00;
  wire         o_req_ready, o_rdata_valid, o_done, o_chip_select_n, o_read_strobe_n;
  wire         o_write_strobe_n, o_fifo_sel, o_data_oe;
  wire  [6:0]  o_addr;
  wire  [31:0] o_rdata, o_data_out, i_data_in, wdat;
  int          bad_count = 0, checked = 0;
  realtime     t_rd = 0, t_wr = 0, p_rd, p_wr, t_go;
  shbp_host_port uut (.*);
  shbp_dev_model dev (.i_core_clk, .i_chip_select_n(o_chip_select_n),
    .i_read_strobe_n(o_read_strobe_n), .i_write_strobe_n(o_write_strobe_n),
    .i_fifo_sel(o_fifo_sel), .i_addr(o_addr), .i_data(o_data_oe ? o_data_out : ~o_data_out),
    .o_data(i_data_in), .o_wr_data(wdat));
  initial forever #12.5 i_core_clk = ~i_core_clk;
  always @(posedge o_read_strobe_n) t_rd = $realtime;
  always @(posedge o_write_strobe_n) t_wr = $realtime;
  task automatic chk(string n, logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick;
    @(posedge i_core_clk);
    #2;
  endtask
  task automatic xf(logic w, x, f, logic [6:0] a, logic [31:0] d, logic [4:0] n);
    int k, b;
    logic [31:0] e;
    k = 0;
    b = 0;
    p_rd = t_rd;
    p_wr = t_wr;
    {i_req_valid, i_req_write, i_req_wide, i_req_fifo, i_req_addr, i_req_wdata, i_req_len}
      = {1'b1, w, x, f, a, d, n};
    while (o_req_ready !== 1'b1 && k < 99) begin
      tick;
      k++;
    end
    t_go = $realtime - 2;
    i_req_valid = 0;
    while (k < 199) begin
      if (o_rdata_valid === 1'b1) begin
        e = f ? {16'hF1F0, 14'h0, a[1:0]} : {16'hA55A, 9'h0, a};
        chk("rdata", o_rdata, x ? e : {16'h0, e[15:0]});
        a = a + (x ? 7'h2 : 7'h1);
        b++;
      end
      if (o_done === 1'b1) break;
      tick;
      k++;
    end
    chk("beats", b, w ? 0 : n == 0 ? 1 : f ? n : n > (x ? 8 : 16) ? (x ? 8 : 16) : n);
    chk("done", o_done, 1);
  endtask
  task automatic t_write;
    xf(1, 1, 0, 7'h11, 32'hDEADBEEF, 0);
    chk("wdata32", wdat, 32'hDEADBEEF);
    xf(1, 0, 0, 7'h12, 32'hCAFE1234, 0);
    chk("wdata16", wdat, 32'h00001234);
  endtask
  task automatic t_read;
    int p;
    xf(0, 1, 0, 7'h1A, 0, 1);
    xf(0, 0, 0, 7'h1B, 0, 0);
    xf(0, 1, 0, 7'h08, 0, 5'h14);
    xf(0, 0, 0, 7'h08, 0, 5'h14);
    p = dev.pops;
    xf(0, 1, 1, 7'h7D, 0, 5'h1F);
    xf(0, 0, 1, 7'h42, 0, 5'h03);
    chk("pops", dev.pops - p, 34);
  endtask
  task automatic t_hazard;
    xf(0, 1, 0, 7'h00, 0, 1);
    xf(0, 1, 0, 7'h3E, 0, 1);
    chk("rx_gap", t_go - p_rd >= 135, 1);
    xf(0, 1, 0, 7'h24, 0, 1);
    xf(0, 1, 0, 7'h40, 0, 1);
    chk("tx_gap", t_go - p_rd >= 135, 1);
    xf(0, 1, 0, 7'h50, 0, 1);
    xf(0, 1, 0, 7'h50, 0, 1);
    chk("drop_gap", t_go - p_rd >= 180, 1);
    xf(1, 1, 0, 7'h30, 32'h5, 0);
    xf(0, 1, 0, 7'h30, 0, 1);
    chk("wr_rd_gap", t_go - p_wr >= 315, 1);
  endtask
  task automatic stop_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) tick;
    i_nrst = 1;
    t_write;
    t_read;
    t_hazard;
    stop_test;
  end
  initial begin
    #(20000 * 25);
    bad_count++;
    stop_test;
  end
endmodule // shbp_host_port_tb
`default_nettype wire
